// >>> cdc_top.sv
`timescale 1ns/100ps
module cdc_top
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [4:0] hSel,
  input wire logic [4:0] vSel,
  input wire logic [1:0] calSel,
  input wire logic [2:0] acquisitionSelect,
  input wire logic [2:0] magnifySelect,
  input wire logic [1:0] dispMode,
  input wire logic invertOn,
  input wire logic leakPositive,
  input wire logic leakNegative,
  input wire logic cfgEmitter,
  input wire logic offsetUpKey,
  input wire logic offsetDownKey,
  input wire logic sampleValid,
  input wire logic [4:0] sampleIdx,
  input wire logic signed [cdc_pkg::SAMPLE_W-1:0] sampleX,
  input wire logic signed [cdc_pkg::SAMPLE_W-1:0] sampleY,
  input wire logic sweepEnd,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic lampDrainH,
  output logic lampControlH,
  output logic lampStaircaseH,
  output logic lampDrainV,
  output logic lampStaircaseV,
  output logic lampEmitter,
  output logic lampInvert,
  output logic hMeasureBase,
  output logic hMeasureEmitter,
  output logic hReadoutOn,
  output logic hCursorReadoutOn,
  output logic vReadoutOn,
  output logic vCursorReadoutOn,
  output logic [2:0] hScaleMant,
  output logic signed [5:0] hScaleExp,
  output logic [2:0] vScaleMant,
  output logic signed [5:0] vScaleExp,
  output logic avgCountShow,
  output logic [5:0] avgCount,
  output logic dispValid,
  output logic signed [15:0] dispX,
  output logic signed [15:0] dispY,
  output logic envXAxis,
  output logic envYAxis,
  output logic signed [15:0] envLo,
  output logic signed [15:0] envHi
);
  import cdc_pkg::*;

  typedef struct packed {
    cdc_pins_type s1;
    cdc_pins_type s2;
    cdc_pins_type s3;
    cdc_pins_type pin;
    logic [23:0] lastSet;
    logic prevUp;
    logic prevDown;
    logic signed [5:0] offset;
    logic [5:0] acqCount;
    logic freeze;
    logic ack;
    logic [31:0] rdata;
    logic outValid;
    logic signed [15:0] outX;
    logic signed [15:0] outY;
    logic signed [15:0] outLo;
    logic signed [15:0] outHi;
    logic [POINTS-1:0][$bits(cdc_point_type)-1:0] mem;
  } cdc_state_type;

  cdc_state_type s;
  cdc_state_type next_s;
  cdc_pins_type pinsRaw;
  cdc_pins_type p;
  cdc_hsrc_type hSource;
  cdc_vsrc_type vSource;
  logic [23:0] curSet;
  logic settingChange;
  logic upPress;
  logic downPress;
  logic bothKeys;
  logic magOff;
  logic storeMode;
  logic avgMode;
  logic [5:0] avgLimit;
  logic busWrite;
  logic busRead;
  logic ctrlRestart;
  logic ctrlOffClr;
  logic [8:0] hScale;
  logic [8:0] vScale;
  logic [4:0] hPos;

  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  function automatic logic [8:0] scale125(input logic [4:0] idx, input logic [1:0] ph0,
                                          input logic signed [5:0] e0);
    logic [5:0] tot;
    logic [5:0] dec;
    logic [2:0] mant;
    tot = {1'b0, idx} + {4'h0, ph0};
    dec = tot / 6'd3;
    unique case (tot % 6'd3)
      6'd0: mant = 3'h1;
      6'd1: mant = 3'h2;
      default: mant = 3'h5;
    endcase
    return {mant, 6'(e0 + $signed(dec))};
  endfunction

  function automatic logic [2:0] avgShift(input logic [5:0] cnt, input logic [5:0] lim);
    logic [5:0] n;
    n = (cnt + 6'h01 < lim) ? cnt + 6'h01 : lim;
    if (n >= 6'h20) return 3'h5;
    else if (n >= 6'h10) return 3'h4;
    else if (n >= 6'h08) return 3'h3;
    else if (n >= 6'h04) return 3'h2;
    else if (n >= 6'h02) return 3'h1;
    else return 3'h0;
  endfunction

  // mirror, magnify and shift one axis value
  function automatic logic signed [15:0] axisMap(input logic signed [SAMPLE_W-1:0] v,
                                                 input logic inv, input logic ten,
                                                 input logic unity, input logic signed [5:0] off);
    logic signed [15:0] t;
    logic signed [15:0] shift;
    t = inv ? -16'(v) : 16'(v);
    shift = 16'(off * HALF_DIV);
    if (ten)
      t = 16'(t * 16'sh000A) + shift;
    else if (unity)
      t = t + shift;
    return t;
  endfunction

  // -------------------------------------------------
  // source and scale decode
  // -------------------------------------------------
  assign pinsRaw = {hSel, vSel, calSel, acquisitionSelect, magnifySelect, dispMode, invertOn,
                    leakPositive, leakNegative, cfgEmitter, offsetUpKey, offsetDownKey};
  assign p = s.pin;
  assign curSet = p[$bits(cdc_pins_type)-1:2];

  always_comb
  begin
    if (p.hSel == H_STAIR_POS)
      hSource = HSRC_STAIR;
    else if (p.hSel <= H_CTRL_LAST)
      hSource = HSRC_CONTROL;
    else
      hSource = HSRC_DRAIN;
    if (p.vSel == V_STAIR_POS)
      vSource = VSRC_STAIR;
    else if (p.leakPositive || p.leakNegative)
      vSource = VSRC_EMITTER;
    else
      vSource = VSRC_DRAIN;
  end

  // control range: position 1 is 50 mV, 6 is 2 V; drain: 19 is 50 mV, 7 is 500 V
  // positions past full clockwise hold the 50 mV step
  assign hPos = (p.hSel > H_DRAIN_LAST) ? H_DRAIN_LAST : p.hSel;
  assign hScale = (hSource == HSRC_DRAIN) ?
                  scale125(5'(H_DRAIN_LAST - hPos), H_START_PHASE, H_START_EXP) :
                  scale125(5'(p.hSel - 5'h01), H_START_PHASE, H_START_EXP);
  assign vScale = scale125(5'(p.vSel - 5'h01), V_START_PHASE, V_START_EXP);
  assign hScaleMant = hScale[8:6];
  assign hScaleExp = hScale[5:0];
  assign vScaleMant = vScale[8:6];
  assign vScaleExp = (vSource == VSRC_EMITTER) ? vScale[5:0] - LEAK_EXP_SHIFT : vScale[5:0];

  assign lampDrainH = (hSource == HSRC_DRAIN);
  assign lampControlH = (hSource == HSRC_CONTROL);
  assign lampStaircaseH = (hSource == HSRC_STAIR);
  assign hReadoutOn = (hSource != HSRC_STAIR);
  assign hCursorReadoutOn = (hSource != HSRC_STAIR);
  assign hMeasureBase = (hSource == HSRC_CONTROL) && !p.cfgEmitter;
  assign hMeasureEmitter = (hSource == HSRC_CONTROL) && p.cfgEmitter;
  assign lampDrainV = (vSource == VSRC_DRAIN);
  assign lampStaircaseV = (vSource == VSRC_STAIR);
  assign vReadoutOn = (vSource != VSRC_STAIR);
  assign vCursorReadoutOn = (vSource != VSRC_STAIR);
  assign lampEmitter = p.leakPositive || p.leakNegative;
  assign lampInvert = p.invertOn;

  // -------------------------------------------------
  // control terms
  // -------------------------------------------------
  assign settingChange = (curSet != s.lastSet);
  assign magOff = (p.magSel != MAG_X_UNITY) && (p.magSel != MAG_X_TEN) &&
                  (p.magSel != MAG_Y_UNITY) && (p.magSel != MAG_Y_TEN);
  assign bothKeys = p.offsetUpKey && p.offsetDownKey;
  assign upPress = p.offsetUpKey && !s.prevUp && !p.offsetDownKey;
  assign downPress = p.offsetDownKey && !s.prevDown && !p.offsetUpKey;
  assign storeMode = (p.dispMode == MODE_STORE);
  assign avgMode = (p.acqSel == ACQ_AVG4) || (p.acqSel == ACQ_AVG32);
  assign avgLimit = (p.acqSel == ACQ_AVG32) ? AVG32_COUNT : AVG4_COUNT;
  // writes land on the edge that sees waitrequest low
  assign busWrite = avs_write && s.ack;
  assign busRead = avs_read && !s.ack;
  assign ctrlRestart = busWrite && (avs_address == REG_CONTROL) && avs_byteenable[0] &&
                       avs_writedata[CTRL_RESTART];
  assign ctrlOffClr = busWrite && (avs_address == REG_CONTROL) && avs_byteenable[0] &&
                      avs_writedata[CTRL_OFFCLR];

  assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
  assign avs_readdata = s.rdata;
  assign avgCountShow = storeMode && avgMode;
  assign avgCount = s.acqCount;
  assign dispValid = s.outValid;
  assign dispX = s.outX;
  assign dispY = s.outY;
  assign envLo = s.outLo;
  assign envHi = s.outHi;
  assign envXAxis = storeMode && (p.acqSel == ACQ_X_ENV);
  assign envYAxis = storeMode && (p.acqSel == ACQ_Y_ENV);

  // -------------------------------------------------
  // next state
  // -------------------------------------------------
  always_comb
  begin
    cdc_point_type w;
    logic first;
    logic [2:0] sh;
    logic xTen;
    logic xUni;
    logic yTen;
    logic yUni;
    logic mirror;
    logic signed [SAMPLE_W-1:0] srcX;
    logic signed [SAMPLE_W-1:0] srcY;
    logic signed [SAMPLE_W:0] dx;
    logic signed [SAMPLE_W:0] dy;
    w = '0;
    first = 1'b0;
    sh = 3'h0;
    xTen = 1'b0;
    xUni = 1'b0;
    yTen = 1'b0;
    yUni = 1'b0;
    mirror = 1'b0;
    srcX = sampleX;
    srcY = sampleY;
    dx = '0;
    dy = '0;
    next_s = s;
    // pin synchroniser, a change counts once stages two and three agree
    next_s.s1 = pinsRaw;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.pin = (s.s2 & ~(s.s2 ^ s.s3)) | (s.pin & (s.s2 ^ s.s3));
    next_s.lastSet = curSet;
    next_s.prevUp = p.offsetUpKey;
    next_s.prevDown = p.offsetDownKey;

    // offset keys
    if (ctrlOffClr)
      next_s.offset = '0;
    else if (!magOff)
    begin
      if (bothKeys)
        next_s.offset = '0;
      else if (upPress && s.offset < OFFSET_LIMIT)
        next_s.offset = s.offset + 6'sd1;
      else if (downPress && s.offset > -OFFSET_LIMIT)
        next_s.offset = s.offset - 6'sd1;
    end

    // stored acquisition
    first = (s.acqCount == 6'h00);
    sh = avgShift(s.acqCount, avgLimit);
    w = s.mem[sampleIdx];
    dx = (SAMPLE_W + 1)'(sampleX) - (SAMPLE_W + 1)'(w.x);
    dy = (SAMPLE_W + 1)'(sampleY) - (SAMPLE_W + 1)'(w.y);
    unique case (p.acqSel)
      ACQ_X_ENV, ACQ_Y_ENV:
      begin
        w.x = sampleX;
        w.y = sampleY;
        if (first)
        begin
          w.lo = (p.acqSel == ACQ_X_ENV) ? sampleX : sampleY;
          w.hi = w.lo;
        end
        else if (p.acqSel == ACQ_X_ENV)
        begin
          w.lo = (sampleX < w.lo) ? sampleX : w.lo;
          w.hi = (sampleX > w.hi) ? sampleX : w.hi;
        end
        else
        begin
          w.lo = (sampleY < w.lo) ? sampleY : w.lo;
          w.hi = (sampleY > w.hi) ? sampleY : w.hi;
        end
      end
      ACQ_AVG4, ACQ_AVG32:
      begin
        if (first)
        begin
          w.x = sampleX;
          w.y = sampleY;
        end
        else
        begin
          w.x = SAMPLE_W'(w.x + SAMPLE_W'(dx >>> sh));
          w.y = SAMPLE_W'(w.y + SAMPLE_W'(dy >>> sh));
        end
      end
      default:
      begin
        w.x = sampleX;
        w.y = sampleY;
      end
    endcase
    if (sampleValid && storeMode && !s.freeze)
      next_s.mem[sampleIdx] = w;
    if (storeMode)
    begin
      srcX = w.x;
      srcY = w.y;
    end

    if (settingChange || ctrlRestart)
      next_s.acqCount = '0;
    else if (sweepEnd && storeMode && !s.freeze)
    begin
      if (avgMode)
        next_s.acqCount = (s.acqCount < avgLimit) ? s.acqCount + 6'h01 : avgLimit;
      else if (s.acqCount != COUNT_MAX)
        next_s.acqCount = s.acqCount + 6'h01;
    end

    // display transform, none of it but calibration for cassette view
    if (p.dispMode != MODE_VIEW)
    begin
      mirror = p.invertOn;
      xTen = (p.magSel == MAG_X_TEN);
      yTen = (p.magSel == MAG_Y_TEN);
      xUni = (p.magSel == MAG_X_UNITY);
      yUni = (p.magSel == MAG_Y_UNITY);
    end
    next_s.outValid = sampleValid;
    if (sampleValid)
    begin
      next_s.outX = axisMap(srcX, mirror, xTen, xUni, s.offset);
      next_s.outY = axisMap(srcY, mirror, yTen, yUni, s.offset);
      next_s.outLo = axisMap(w.lo, mirror, (p.acqSel == ACQ_X_ENV) ? xTen : yTen,
                             (p.acqSel == ACQ_X_ENV) ? xUni : yUni, s.offset);
      next_s.outHi = axisMap(w.hi, mirror, (p.acqSel == ACQ_X_ENV) ? xTen : yTen,
                             (p.acqSel == ACQ_X_ENV) ? xUni : yUni, s.offset);
      if (p.calSel == CAL_FULL)
      begin
        next_s.outX = 16'(CAL_ORIGIN + 16'(CAL_DIVS * COUNTS_PER_DIV));
        next_s.outY = 16'(CAL_ORIGIN + 16'(CAL_DIVS * COUNTS_PER_DIV));
      end
      else if (p.calSel == CAL_ZERO)
      begin
        next_s.outX = CAL_ORIGIN;
        next_s.outY = CAL_ORIGIN;
      end
    end

    // -------------------------------------------------
    // avalon slave, one wait cycle per access
    // -------------------------------------------------
    next_s.ack = (avs_read || avs_write) && !s.ack;
    if (busWrite && avs_address == REG_CONTROL && avs_byteenable[0])
      next_s.freeze = avs_writedata[CTRL_FREEZE];
    if (busRead)
    begin
      next_s.rdata = '0;
      unique case (avs_address)
        REG_STATUS:
        begin
          next_s.rdata[STAT_COUNT_LSB +: 6] = s.acqCount;
          next_s.rdata[STAT_OFFSET_LSB +: 6] = s.offset;
          next_s.rdata[STAT_HSRC_LSB +: 2] = hSource;
          next_s.rdata[STAT_VSRC_LSB +: 2] = vSource;
          next_s.rdata[STAT_AVG_BIT] = avgCountShow;
        end
        REG_CONTROL: next_s.rdata[CTRL_FREEZE] = s.freeze;
        REG_SCALE:
        begin
          next_s.rdata[8:0] = hScale;
          next_s.rdata[SCALE_V_LSB +: 9] = {vScaleMant, vScaleExp};
        end
        default: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.freeze <= CTRL_FREEZE_RESET;
    end
    else
      s <= next_s;
  end

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence upStepSeq;
    upPress && !magOff && !ctrlOffClr && (s.offset < OFFSET_LIMIT);
  endsequence
  sequence bothClearSeq;
    bothKeys && !magOff;
  endsequence

  a_drain_source: assert property (lampDrainH |-> hReadoutOn && p.hSel > H_CTRL_LAST)
    else $error("drain source without readout");
  a_horiz_blank: assert property ((p.hSel == H_STAIR_POS) |-> lampStaircaseH && !hReadoutOn && !hCursorReadoutOn)
    else $error("horizontal staircase readouts not blanked");
  a_vert_blank: assert property ((p.vSel == V_STAIR_POS) |-> lampStaircaseV && !vReadoutOn && !vCursorReadoutOn)
    else $error("vertical staircase readouts not blanked");
  a_leak_divide: assert property ((vSource == VSRC_EMITTER) |-> lampEmitter && vScaleExp == vScale[5:0] - 6'sd3)
    else $error("leak_positive scale not divided by 1000");
  a_offset_step: assert property (upStepSeq |=> s.offset == $past(s.offset) + 6'sd1)
    else $error("offset key did not step by half division");
  a_offset_limit: assert property (s.offset <= 6'sd20 && s.offset >= -6'sd20)
    else $error("offset beyond ten divisions");
  a_offset_clear: assert property (bothClearSeq |=> s.offset == 6'sd0)
    else $error("both keys did not clear offset");
  a_keys_ignored: assert property (magOff && !ctrlOffClr |=> $stable(s.offset))
    else $error("offset moved with magnify off");
  a_restart_count: assert property (settingChange |=> avgCount == 6'h00)
    else $error("count not restarted on setting change");
  a_avg_bound: assert property (avgMode && !settingChange |=> avgCount <= 6'h20)
    else $error("averaging count beyond limit");
  a_cal_full: assert property (sampleValid && p.calSel == CAL_FULL |=> dispX == 16'sd500 && dispY == 16'sd500)
    else $error("full scale check not ten divisions");
  a_view_plain: assert property (sampleValid && p.dispMode == MODE_VIEW && p.calSel == 2'h0 |=> dispX == 16'($past(sampleX)))
    else $error("view curve altered");
endmodule

// >>> cdc_pkg.sv
package cdc_pkg;
  // -------------------------------------------------
  // register map
  // -------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam logic [3:0] REG_SCALE = 4'h8;
  localparam int CTRL_FREEZE = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_OFFCLR = 2;
  localparam logic CTRL_FREEZE_RESET = 1'h0;
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_OFFSET_LSB = 8;
  localparam int STAT_HSRC_LSB = 16;
  localparam int STAT_VSRC_LSB = 18;
  localparam int STAT_AVG_BIT = 20;
  localparam int SCALE_V_LSB = 16;
  // -------------------------------------------------
  // selector positions and pin codes
  // -------------------------------------------------
  localparam logic [4:0] H_STAIR_POS = 5'h00;
  localparam logic [4:0] H_CTRL_LAST = 5'h06;
  localparam logic [4:0] H_DRAIN_LAST = 5'h13;
  localparam logic [4:0] V_STAIR_POS = 5'h00;
  localparam logic [1:0] CAL_FULL = 2'h1;
  localparam logic [1:0] CAL_ZERO = 2'h2;
  localparam logic [2:0] ACQ_X_ENV = 3'h0;
  localparam logic [2:0] ACQ_Y_ENV = 3'h1;
  localparam logic [2:0] ACQ_PLAIN = 3'h2;
  localparam logic [2:0] ACQ_AVG4 = 3'h3;
  localparam logic [2:0] ACQ_AVG32 = 3'h4;
  localparam logic [2:0] MAG_OFF = 3'h0;
  localparam logic [2:0] MAG_Y_TEN = 3'h1;
  localparam logic [2:0] MAG_Y_UNITY = 3'h2;
  localparam logic [2:0] MAG_X_UNITY = 3'h3;
  localparam logic [2:0] MAG_X_TEN = 3'h4;
  localparam logic [1:0] MODE_LIVE = 2'h0;
  localparam logic [1:0] MODE_STORE = 2'h1;
  localparam logic [1:0] MODE_VIEW = 2'h2;
  // -------------------------------------------------
  // scales and counts
  // -------------------------------------------------
  localparam logic [1:0] H_START_PHASE = 2'h2;
  localparam logic signed [5:0] H_START_EXP = -6'sd2;
  localparam logic [1:0] V_START_PHASE = 2'h0;
  localparam logic signed [5:0] V_START_EXP = -6'sd6;
  localparam logic signed [5:0] LEAK_EXP_SHIFT = 6'sd3;
  localparam logic signed [15:0] COUNTS_PER_DIV = 16'sh0064;
  localparam logic signed [15:0] HALF_DIV = 16'sh0032;
  localparam logic signed [15:0] CAL_ORIGIN = -16'sh01F4;
  localparam logic signed [15:0] CAL_DIVS = 16'sh000A;
  localparam logic signed [5:0] OFFSET_LIMIT = 6'sh14;
  localparam logic [5:0] AVG4_COUNT = 6'h04;
  localparam logic [5:0] AVG32_COUNT = 6'h20;
  localparam logic [5:0] COUNT_MAX = 6'h3F;
  localparam int POINTS = 32;
  localparam int SAMPLE_W = 11;

  typedef enum logic [1:0] {HSRC_STAIR, HSRC_CONTROL, HSRC_DRAIN} cdc_hsrc_type;
  typedef enum logic [1:0] {VSRC_STAIR, VSRC_DRAIN, VSRC_EMITTER} cdc_vsrc_type;

  typedef struct packed {
    logic [4:0] hSel;
    logic [4:0] vSel;
    logic [1:0] calSel;
    logic [2:0] acqSel;
    logic [2:0] magSel;
    logic [1:0] dispMode;
    logic invertOn;
    logic leakPositive;
    logic leakNegative;
    logic cfgEmitter;
    logic offsetUpKey;
    logic offsetDownKey;
  } cdc_pins_type;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] x;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] lo;
    logic signed [SAMPLE_W-1:0] hi;
  } cdc_point_type;
endpackage

// >>> cdc_panel_model.sv
`timescale 1ns/100ps
module cdc_panel_model
(
  input wire logic clk_sys,
  output logic offsetUpKey,
  output logic offsetDownKey
);
  initial
  begin
    offsetUpKey = 1'b0;
    offsetDownKey = 1'b0;
  end
  // keys held long enough to pass the pin synchroniser
  task automatic press(input logic up, input logic down);
    @(posedge clk_sys);
    offsetUpKey <= up;
    offsetDownKey <= down;
    repeat (8) @(posedge clk_sys);
    offsetUpKey <= 1'b0;
    offsetDownKey <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
  import cdc_pkg::*;
  logic clk_sys = 0, rst_b = 0, invertOn = 0, leakPositive = 0, leakNegative = 0;
  logic cfgEmitter = 0, sampleValid = 0, sweepEnd = 0, avs_read = 0, avs_write = 0;
  logic [4:0] hSel = 5'h13, vSel = 5'h01, sampleIdx = 5'h00;
  logic [1:0] calSel = 2'h0, dispMode = MODE_LIVE;
  logic [2:0] acquisitionSelect = ACQ_PLAIN, magnifySelect = MAG_OFF;
  logic signed [10:0] sampleX = 0, sampleY = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, rd;
  int mismatches = 0, nChecks = 0;
  logic up, down;
  logic avs_waitrequest, lampDrainH, lampControlH, lampStaircaseH, lampDrainV, lampStaircaseV;
  logic lampEmitter, lampInvert, hMeasureBase, hMeasureEmitter, hReadoutOn, hCursorReadoutOn;
  logic vReadoutOn, vCursorReadoutOn, avgCountShow, dispValid, envXAxis, envYAxis;
  logic [31:0] avs_readdata;
  logic [2:0] hScaleMant, vScaleMant;
  logic signed [5:0] hScaleExp, vScaleExp;
  logic [5:0] avgCount;
  logic signed [15:0] dispX, dispY, envLo, envHi;
  always #10 clk_sys = ~clk_sys;
  cdc_panel_model panel (.clk_sys(clk_sys), .offsetUpKey(up), .offsetDownKey(down));
  cdc_top dut (.*, .offsetUpKey(up), .offsetDownKey(down));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    logic waiting;
    logic [31:0] seen;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    // values standing at the coming edge, seen half a cycle before it
    do
    begin
      @(negedge clk_sys);
      waiting = avs_waitrequest;
      seen = avs_readdata;
      @(posedge clk_sys);
    end
    while (waiting !== 1'b0);
    rd = seen;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic sweep;
    @(posedge clk_sys);
    sweepEnd <= 1'b1;
    @(posedge clk_sys);
    sweepEnd <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic sample(input logic signed [10:0] x, input logic signed [10:0] y);
    @(posedge clk_sys);
    sampleValid <= 1'b1;
    sampleX <= x;
    sampleY <= y;
    @(posedge clk_sys);
    sampleValid <= 1'b0;
    @(negedge clk_sys);
    chk(dispValid, 1);
  endtask
  task automatic test_horizontal;
    settle();
    chk({lampDrainH, lampControlH, lampStaircaseH, hReadoutOn}, 4'h9);
    chk({hScaleMant, hScaleExp}, {3'h5, 6'h3E});
    hSel <= 5'h07;
    settle();
    chk({hScaleMant, hScaleExp}, {3'h5, 6'h02});
    hSel <= 5'h06;
    settle();
    chk({lampDrainH, lampControlH, hScaleMant, hScaleExp}, {2'h1, 3'h2, 6'h00});
    chk({hMeasureBase, hMeasureEmitter}, 2'h2);
    hSel <= 5'h01;
    cfgEmitter <= 1'b1;
    settle();
    chk({hScaleMant, hScaleExp}, {3'h5, 6'h3E});
    chk({hMeasureBase, hMeasureEmitter}, 2'h1);
    hSel <= 5'h00;
    settle();
    chk({lampStaircaseH, hReadoutOn, hCursorReadoutOn}, 3'h4);
    $display("horizontal test done");
  endtask
  task automatic test_vertical;
    chk({lampDrainV, vScaleMant, vScaleExp}, {1'b1, 3'h1, 6'h3A});
    vSel <= 5'h02;
    leakNegative <= 1'b1;
    settle();
    chk({lampEmitter, lampDrainV, vScaleMant, vScaleExp}, {2'h2, 3'h2, 6'h37});
    vSel <= 5'h00;
    leakNegative <= 1'b0;
    settle();
    chk({lampStaircaseV, vReadoutOn, vCursorReadoutOn}, 3'h4);
    $display("vertical test done");
  endtask
  task automatic test_invert_cal;
    invertOn <= 1'b1;
    settle();
    sample(100, -50);
    chk(lampInvert, 1);
    chk({dispX, dispY}, {16'hFF9C, 16'h0032});
    @(posedge clk_sys);
    invertOn <= 1'b0;
    calSel <= CAL_FULL;
    settle();
    sample(3, 3);
    chk({dispX, dispY}, {16'h01F4, 16'h01F4});
    @(posedge clk_sys);
    calSel <= CAL_ZERO;
    settle();
    sample(3, 3);
    chk({dispX, dispY}, {16'hFE0C, 16'hFE0C});
    @(posedge clk_sys);
    calSel <= 2'h0;
    settle();
    $display("invert and calibration test done");
  endtask
  task automatic test_offset;
    panel.press(1, 0);
    bus(0, REG_STATUS, 0);
    chk(rd[13:8], 0);
    magnifySelect <= MAG_Y_UNITY;
    settle();
    panel.press(1, 0);
    panel.press(1, 0);
    sample(0, 0);
    chk(dispY, 16'h0064);
    panel.press(1, 1);
    sample(0, 0);
    chk(dispY, 0);
    repeat (25) panel.press(1, 0);
    bus(0, REG_STATUS, 0);
    chk(rd[13:8], 6'h14);
    sample(0, 0);
    chk(dispY, 16'h03E8);
    @(posedge clk_sys);
    dispMode <= MODE_VIEW;
    settle();
    sample(0, 7);
    chk(dispY, 7);
    bus(1, REG_CONTROL, 32'h4);
    bus(0, REG_STATUS, 0);
    chk(rd[13:8], 0);
    bus(0, 4'hC, 0);
    chk(rd, 0);
    $display("offset and bus test done");
  endtask
  task automatic test_store;
    magnifySelect <= MAG_OFF;
    dispMode <= MODE_STORE;
    acquisitionSelect <= ACQ_Y_ENV;
    settle();
    chk({envXAxis, envYAxis, avgCount}, {2'h1, 6'h00});
    sample(0, 10);
    sweep();
    sample(0, 30);
    sweep();
    sample(0, -20);
    chk({envLo, envHi}, {16'hFFEC, 16'h001E});
    @(posedge clk_sys);
    acquisitionSelect <= ACQ_AVG4;
    settle();
    chk({avgCountShow, avgCount}, {1'b1, 6'h00});
    sample(0, 40);
    sweep();
    sample(0, 80);
    chk(dispY, 16'h003C);
    repeat (4) sweep();
    chk(avgCount, 6'h04);
    @(posedge clk_sys);
    dispMode <= MODE_LIVE;
    magnifySelect <= MAG_Y_TEN;
    settle();
    sample(0, 5);
    chk(dispY, 16'h0032);
    panel.press(1, 0);
    sample(0, 5);
    chk(dispY, 16'h0064);
    $display("store and magnify test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    test_horizontal();
    test_vertical();
    test_invert_cal();
    test_offset();
    test_store();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end
endmodule
